/* hw/ucc_core.sv */
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "ucc_defines.svh"
module ucc_core #(
    parameter int FILL_W = 5
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire ucc_pkg::ucc_bus_t i_bus,
    output logic [7:0]             o_rdata,
    input  wire logic              i_rx_line_event,
    input  wire logic              i_rx_timeout,
    input  wire logic [FILL_W-1:0] i_rx_fill,
    input  wire logic              i_thr_empty,
    input  wire logic              i_tx_serial,
    input  wire logic [7:0]        i_tx_char,
    input  wire logic [7:0]        i_rx_char,
    input  wire logic              i_rx_par,
    input  wire logic              i_rx_pin,
    input  wire logic              i_cts_n,
    input  wire logic              i_dsr_n,
    input  wire logic              i_dcd_n,
    input  wire logic              i_ri_n,
    output logic                   o_tx,
    output logic                   o_rx_serial,
    output logic                   o_rts_n,
    output logic                   o_dtr_n,
    output logic                   o_user_output_a_n,
    output logic                   o_user_output_b_n,
    output logic                   o_irq,
    output ucc_pkg::ucc_fmt_t      o_fmt,
    output logic                   o_tx_par,
    output logic                   o_rx_par_err,
    output logic [15:0]            o_divisor,
    output logic [7:0]             o_efr,
    output logic                   o_auto_flow_en,
    output logic                   o_fifo_en,
    output logic                   o_rx_fifo_clr,
    output logic                   o_tx_fifo_clr
);
    import ucc_pkg::*;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    logic [7:0]  interrupt_enable_register;
    logic [7:0]  line_format_control;
    logic [7:0]  handshake_control;
    logic [7:0]  dll;
    logic [7:0]  dlm;
    logic [7:0]  efr;
    logic        fifo_en;
    logic [1:0]  trig_sel;
    logic [4:0]  pin_s1;
    logic [4:0]  pin_s2;
    logic [3:0]  mdm_q;
    logic [3:0]  delta;
    logic        f_line;
    logic        f_tmo;
    logic        f_thre;
    logic        thre_q;
    logic        ier_tx_q;
    ucc_src_t    cur;
    ucc_src_t    next_cur;
    logic [7:0]  next_rdata;

    // decode
    wire dlab     = line_format_control[`UCC_LCR_DLAB];
    wire loop     = handshake_control[`UCC_MCR_LOOP];
    wire wr_dll   = i_bus.we && i_bus.addr == `UCC_OFF_DLL && dlab;
    wire wr_ier   = i_bus.we && i_bus.addr == `UCC_OFF_IER && !dlab;
    wire wr_dlm   = i_bus.we && i_bus.addr == `UCC_OFF_IER && dlab;
    wire wr_fcr   = i_bus.we && i_bus.addr == `UCC_OFF_ISR && !dlab;
    wire wr_efr   = i_bus.we && i_bus.addr == `UCC_OFF_ISR && dlab;
    wire wr_lcr   = i_bus.we && i_bus.addr == `UCC_OFF_LCR;
    wire wr_mcr   = i_bus.we && i_bus.addr == `UCC_OFF_MCR;
    wire rd_isr   = i_bus.re && i_bus.addr == `UCC_OFF_ISR && !dlab;
    wire rd_msr   = i_bus.re && i_bus.addr == `UCC_OFF_MSR;

    // line format
    wire [1:0] wlen  = line_format_control[1:0];
    wire       pen   = line_format_control[`UCC_LCR_PEN];
    wire       peven = line_format_control[`UCC_LCR_EVEN];
    wire       pstk  = line_format_control[`UCC_LCR_STICK];
    wire       slong = line_format_control[`UCC_LCR_STOP];
    wire [2:0] halves = !slong ? 3'h2 : (wlen == 2'h0 ? 3'h3 : 3'h4);
    wire [7:0] len_mask = 8'hFF >> (3'h3 - {1'b0, wlen});

    function automatic logic par_of(input logic [7:0] d,
                                    input logic [7:0] m,
                                    input logic ev,
                                    input logic stk);
        // odd parity sets the bit so the total count of ones is odd
        if (stk)
            par_of = !ev;
        else
            par_of = ev ? ^(d & m) : !(^(d & m));
    endfunction

    wire tx_par_gen = par_of(i_tx_char, len_mask, peven, pstk);
    wire rx_par_x = par_of(i_rx_char, len_mask, peven, pstk);
    wire rx_bad   = pen && (rx_par_x != i_rx_par);

    // serial path and loopback
    wire tx_int  = line_format_control[`UCC_LCR_BRK] ? 1'b0 : i_tx_serial;
    wire rx_pin  = pin_s2[4];

    // modem inputs: true sense, taken from control bits in loopback
    wire [3:0] mdm_pin = ~pin_s2[3:0];
    wire [3:0] mdm_loop = {handshake_control[`UCC_MCR_USR_B], handshake_control[`UCC_MCR_USR_A],
                           handshake_control[`UCC_MCR_DTR], handshake_control[`UCC_MCR_RTS]};
    wire [3:0] mdm_now = loop ? mdm_loop : mdm_pin;
    wire [3:0] next_delta_set = {mdm_now[3] ^ mdm_q[3],
                                 mdm_q[2] & !mdm_now[2],
                                 mdm_now[1] ^ mdm_q[1],
                                 mdm_now[0] ^ mdm_q[0]};

    // rx trigger level
    wire [4:0] trig = trig_sel == 2'h0 ? `UCC_TRIG_0 :
                      trig_sel == 2'h1 ? `UCC_TRIG_1 :
                      trig_sel == 2'h2 ? `UCC_TRIG_2 : `UCC_TRIG_3;
    wire [FILL_W-1:0] trig_w = FILL_W'(trig);
    wire rx_avail = fifo_en ? (i_rx_fill >= trig_w)
                            : (i_rx_fill != '0);

    // pending vector, index = priority order
    wire thre_set = i_thr_empty && interrupt_enable_register[`UCC_IER_TX] &&
                    (!thre_q || !ier_tx_q);
    wire [4:0] pend = {
        interrupt_enable_register[`UCC_IER_MS] && delta != 4'h0,
        interrupt_enable_register[`UCC_IER_TX] && f_thre,
        interrupt_enable_register[`UCC_IER_RX] && f_tmo,
        interrupt_enable_register[`UCC_IER_RX] && rx_avail,
        interrupt_enable_register[`UCC_IER_LS] && f_line};

    function automatic ucc_src_t pick(input logic [4:0] v);
        // fixed priority: line, data, time-out, transmit, modem
        if (v[0])      pick = SRC_LINE;
        else if (v[1]) pick = SRC_RXDATA;
        else if (v[2]) pick = SRC_TMO;
        else if (v[3]) pick = SRC_THRE;
        else if (v[4]) pick = SRC_MODEM;
        else           pick = SRC_NONE;
    endfunction

    function automatic logic [4:0] mask_of(input ucc_src_t s);
        case (s)
            SRC_LINE:   mask_of = 5'h01;
            SRC_RXDATA: mask_of = 5'h02;
            SRC_TMO:    mask_of = 5'h04;
            SRC_THRE:   mask_of = 5'h08;
            SRC_MODEM:  mask_of = 5'h10;
            default:    mask_of = 5'h00;
        endcase
    endfunction

    function automatic logic [3:0] code_of(input ucc_src_t s);
        case (s)
            SRC_LINE:   code_of = `UCC_ID_LINE;
            SRC_RXDATA: code_of = `UCC_ID_RXDATA;
            SRC_TMO:    code_of = `UCC_ID_TMO;
            SRC_THRE:   code_of = `UCC_ID_THRE;
            SRC_MODEM:  code_of = `UCC_ID_MODEM;
            default:    code_of = `UCC_ID_NONE;
        endcase
    endfunction

    wire [4:0] cur_mask = mask_of(cur);
    wire cur_live = (pend & cur_mask) != 5'h0;
    // the reported source only moves once it is serviced or gone
    always_comb begin
        if (rd_isr)
            next_cur = pick(pend & ~cur_mask);
        else if (cur == SRC_NONE || !cur_live)
            next_cur = pick(pend);
        else
            next_cur = cur;
    end

    // clearing by INTERRUPT_IDENTIFICATION read applies only to the source being shown
    wire clr_line = rd_isr && cur == SRC_LINE;
    wire clr_tmo  = rd_isr && cur == SRC_TMO;
    wire clr_thre = (rd_isr && cur == SRC_THRE) || !i_thr_empty;
    wire clr_mdm  = rd_msr || (rd_isr && cur == SRC_MODEM);

    wire [7:0] isr_val = {{2{fifo_en}}, 2'b00, code_of(cur)};

    always_comb begin
        case (i_bus.addr)
            `UCC_OFF_DLL: next_rdata = dlab ? dll : 8'h00;
            `UCC_OFF_IER: next_rdata = dlab ? dlm : {4'h0, interrupt_enable_register[3:0]};
            `UCC_OFF_ISR: next_rdata = dlab ? efr : isr_val;
            `UCC_OFF_LCR: next_rdata = line_format_control;
            `UCC_OFF_MCR: next_rdata = handshake_control;
            `UCC_OFF_MSR: next_rdata = {mdm_now, delta};
            default:      next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= `UCC_RST_BYTE;
        end else begin
            o_rdata <= i_bus.re ? next_rdata : 8'h00;
        end
    end

    // software registers
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            interrupt_enable_register <= `UCC_RST_BYTE;
            line_format_control <= `UCC_RST_BYTE;
            handshake_control <= `UCC_RST_BYTE;
            dll <= `UCC_RST_BYTE;
            dlm <= `UCC_RST_BYTE;
            efr <= `UCC_RST_BYTE;
        end else begin
            if (wr_ier) interrupt_enable_register <= {4'h0, i_bus.wdata[3:0]};
            if (wr_lcr) line_format_control <= i_bus.wdata;
            if (wr_mcr) handshake_control <= {2'b00, i_bus.wdata[5:0]};
            if (wr_dll) dll <= i_bus.wdata;
            if (wr_dlm) dlm <= i_bus.wdata;
            if (wr_efr) efr <= i_bus.wdata;
        end
    end

    // other control bits only take effect with the enable bit set
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fifo_en       <= 1'b0;
            trig_sel      <= 2'h0;
            o_rx_fifo_clr <= 1'b0;
            o_tx_fifo_clr <= 1'b0;
        end else begin
            o_rx_fifo_clr <= wr_fcr && i_bus.wdata[0] && i_bus.wdata[1];
            o_tx_fifo_clr <= wr_fcr && i_bus.wdata[0] && i_bus.wdata[2];
            if (wr_fcr) begin
                fifo_en <= i_bus.wdata[0];
                if (i_bus.wdata[0]) trig_sel <= i_bus.wdata[7:6];
            end
        end
    end

    // pins pass two flops; first stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1 <= 5'h1F;
            pin_s2 <= 5'h1F;
        end else begin
            pin_s1 <= {i_rx_pin, i_dcd_n, i_ri_n, i_dsr_n, i_cts_n};
            pin_s2 <= pin_s1;
        end
    end

    // sticky event flags: a set in the clear cycle wins
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            f_line   <= 1'b0;
            f_tmo    <= 1'b0;
            f_thre   <= 1'b0;
            thre_q   <= 1'b0;
            ier_tx_q <= 1'b0;
            mdm_q    <= 4'h0;
            delta    <= 4'h0;
            cur      <= SRC_NONE;
        end else begin
            f_line   <= i_rx_line_event || (f_line && !clr_line);
            f_tmo    <= i_rx_timeout || (f_tmo && !clr_tmo);
            f_thre   <= thre_set || (f_thre && !clr_thre);
            thre_q   <= i_thr_empty;
            ier_tx_q <= interrupt_enable_register[`UCC_IER_TX];
            mdm_q    <= mdm_now;
            delta    <= next_delta_set | (clr_mdm ? 4'h0 : delta);
            cur      <= next_cur;
        end
    end

    // registered outputs
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx              <= 1'b1;
            o_rx_serial       <= 1'b1;
            o_rts_n           <= 1'b1;
            o_dtr_n           <= 1'b1;
            o_user_output_a_n <= 1'b1;
            o_user_output_b_n <= 1'b1;
            o_tx_par          <= 1'b0;
            o_rx_par_err      <= 1'b0;
        end else begin
            o_tx              <= loop ? 1'b1 : tx_int;
            o_rx_serial       <= loop ? tx_int : rx_pin;
            o_rts_n           <= loop || !handshake_control[`UCC_MCR_RTS];
            o_dtr_n           <= loop || !handshake_control[`UCC_MCR_DTR];
            o_user_output_a_n <= loop || !handshake_control[`UCC_MCR_USR_A];
            o_user_output_b_n <= loop || !handshake_control[`UCC_MCR_USR_B];
            o_tx_par          <= tx_par_gen;
            o_rx_par_err      <= rx_bad;
        end
    end

    assign o_irq = cur != SRC_NONE;
    assign o_fmt = '{wlen: wlen, stop_long: slong, par_en: pen,
                     par_even: peven, par_stick: pstk,
                     stop_halves: halves};
    assign o_divisor      = {dlm, dll};
    assign o_efr          = efr;
    assign o_auto_flow_en = handshake_control[`UCC_MCR_AFE];
    assign o_fifo_en      = fifo_en;

    // checks
    sequence s_isr_rd;
        i_bus.re && i_bus.addr == `UCC_OFF_ISR && !dlab;
    endsequence

    sequence s_line_shown;
        cur == SRC_LINE && !i_rx_line_event;
    endsequence

    line_code_a: assert property (
        s_isr_rd ##0 cur == SRC_LINE |=> o_rdata[3:0] == 4'h6)
        else $error("line status code wrong");

    read_clear_a: assert property (
        s_isr_rd ##0 s_line_shown |=> !f_line)
        else $error("line flag not cleared by read");

    hold_src_a: assert property (
        cur != SRC_NONE && cur_live && !i_bus.re |=> cur == $past(cur))
        else $error("reported source changed");

    irq_bit0_a: assert property (
        s_isr_rd ##0 o_irq |=> !o_rdata[0])
        else $error("bit 0 high with irq");

    fifo_bits_a: assert property (
        s_isr_rd |=> o_rdata[7:6] == {2{$past(fifo_en)}})
        else $error("fifo bits wrong");

    break_tx_a: assert property (
        line_format_control[`UCC_LCR_BRK] && !loop |=> !o_tx)
        else $error("break not driven");

    loop_iso_a: assert property (
        loop [*2] |-> o_tx && o_rts_n && o_dtr_n)
        else $error("pins not released in loopback");

    rts_inv_a: assert property (
        !loop |=> o_rts_n == !$past(handshake_control[`UCC_MCR_RTS]))
        else $error("rts not inverted");

    dlab_ier_a: assert property (
        i_bus.we && i_bus.addr == `UCC_OFF_IER && dlab |=> interrupt_enable_register == $past(interrupt_enable_register))
        else $error("ier written under divisor access");

    stop_len_a: assert property (
        slong && wlen == 2'h0 |-> o_fmt.stop_halves == 3'h3)
        else $error("stop length wrong");

    irq_out_a: assert property (
        pend == 5'h0 && !i_bus.re |=> ##1 !o_irq || $past(pend) != 5'h0)
        else $error("irq without pending source");

    sequence s_rx_trig;
        fifo_en && interrupt_enable_register[`UCC_IER_RX] && i_rx_fill >= trig_w;
    endsequence

    rx_trig_a: assert property (
        s_rx_trig ##0 cur == SRC_NONE |=> o_irq)
        else $error("trigger level not reported");

    thre_code_a: assert property (
        s_isr_rd ##0 cur == SRC_THRE |=> o_rdata[3:0] == `UCC_ID_THRE)
        else $error("transmit empty code wrong");

    masked_line_a: assert property (
        !interrupt_enable_register[`UCC_IER_LS] |=> cur != SRC_LINE)
        else $error("masked line source reported");

    user_b_a: assert property (
        !loop |=> o_user_output_b_n == !$past(handshake_control[`UCC_MCR_USR_B]))
        else $error("user output b not inverted");
endmodule // ucc_core

/* hw/ucc_defines.svh */
// How it works
// - INTERRUPT_IDENTIFICATION read returns code of the reported source
// - reported source held until serviced or gone
// - INTERRUPT_IDENTIFICATION read clears only reported source
// - line status: priority 1, code 0110
// - rx data 0100, timeout 1100, priority 2
// - transmit empty: priority 3, code 0010
// - modem status: priority 4, code 0000
// - INTERRUPT_IDENTIFICATION bits 7:6 show FIFO enable
// - INTERRUPT_IDENTIFICATION bit 0 low while pending
// - line bit 7 maps divisor latch
// - line bit 6 holds transmit low; in loopback the pin stays high and the low goes to the rx loop path
// - line bit 3 enables parity bit
// - line bit 4 picks odd/even
// - line bit 5 forces constant parity
// - line bit 2 selects stop length
// - line bits 1:0 give 5..8 bits
// - handshake bit 4 enters local loopback
// - loopback modem sources from control bits
// - bit 3 drives user output b inverted
// - bit 2 sets loopback ring indicator
// - bits 1:0 drive RTS/DTR inverted
// - bit 5 auto flow; 7:6 reserved
// - each source gated by enable bit
// - FIFO rx interrupt follows trigger level
`ifndef UCC_DEFINES_SVH
`define UCC_DEFINES_SVH
`define UCC_OFF_DLL    8'h00
`define UCC_OFF_IER    8'h04
`define UCC_OFF_ISR    8'h08
`define UCC_OFF_LCR    8'h0C
`define UCC_OFF_MCR    8'h10
`define UCC_OFF_MSR    8'h14
`define UCC_LCR_DLAB   7
`define UCC_LCR_BRK    6
`define UCC_LCR_STICK  5
`define UCC_LCR_EVEN   4
`define UCC_LCR_PEN    3
`define UCC_LCR_STOP   2
`define UCC_MCR_AFE    5
`define UCC_MCR_LOOP   4
`define UCC_MCR_USR_B  3
`define UCC_MCR_USR_A  2
`define UCC_MCR_RTS    1
`define UCC_MCR_DTR    0
`define UCC_IER_RX     0
`define UCC_IER_TX     1
`define UCC_IER_LS     2
`define UCC_IER_MS     3
`define UCC_ID_NONE    4'h1
`define UCC_ID_LINE    4'h6
`define UCC_ID_RXDATA  4'h4
`define UCC_ID_TMO     4'hC
`define UCC_ID_THRE    4'h2
`define UCC_ID_MODEM   4'h0
`define UCC_TRIG_0     5'h01
`define UCC_TRIG_1     5'h04
`define UCC_TRIG_2     5'h08
`define UCC_TRIG_3     5'h0E
`define UCC_RST_BYTE   8'h00
`endif

/* hw/ucc_pkg.sv */
package ucc_pkg;
    typedef enum logic [2:0] {
        SRC_NONE, SRC_LINE, SRC_RXDATA, SRC_TMO, SRC_THRE, SRC_MODEM
    } ucc_src_t;
    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ucc_bus_t;
    typedef struct packed {
        logic [1:0] wlen;
        logic       stop_long;
        logic       par_en;
        logic       par_even;
        logic       par_stick;
        logic [2:0] stop_halves;
    } ucc_fmt_t;
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } ucc_mdm_t;
endpackage

/* tb/ucc_modem_model.sv */
`timescale 1ns/1ps
module ucc_modem_model (
    input  wire logic i_core_clk,
    input  wire logic i_line_tx,
    output logic      o_line_rx,
    output logic      o_cts_n,
    output logic      o_dsr_n,
    output logic      o_dcd_n,
    output logic      o_ri_n
);
    // behaves like a wired test plug: line echoed, handshake idle high
    initial begin
        o_line_rx = 1'b1;
        o_cts_n   = 1'b1;
        o_dsr_n   = 1'b1;
        o_dcd_n   = 1'b1;
        o_ri_n    = 1'b1;
    end

    // plain always: the initial block above also sets this line
    always @(posedge i_core_clk) begin
        o_line_rx <= i_line_tx;
    end

    // the far end asserts clear-to-send once; it never drops it again
    task automatic assert_cts();
        @(posedge i_core_clk);
        o_cts_n <= 1'b0;
    endtask
endmodule // ucc_modem_model

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "ucc_defines.svh"
module testbench;
    import ucc_pkg::*;
    logic             clk;
    logic             rst_n;
    ucc_bus_t         bus;
    logic [7:0]       rdata;
    logic             line_ev;
    logic             tmo;
    logic [4:0]       fill;
    logic             thr;
    logic [7:0]       tx_char;
    logic             rx_par;
    logic             tx;
    logic             rx_pin;
    logic             cts_n;
    logic             dsr_n;
    logic             dcd_n;
    logic             ri_n;
    logic             rts_n;
    logic             dtr_n;
    logic             ua_n;
    logic             ub_n;
    logic             irq;
    ucc_fmt_t         fmt;
    logic             tx_par;
    logic             par_err;
    logic [15:0]      divisor;
    logic             afe;
    logic             fifo_en;
    logic [7:0]       v;
    logic [7:0]       efr;
    logic             rx_ser;
    int               err_count;
    int               num_checks;

    ucc_core uut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .o_rdata(rdata),
        .i_rx_line_event(line_ev), .i_rx_timeout(tmo), .i_rx_fill(fill),
        .i_thr_empty(thr), .i_tx_serial(1'b1), .i_tx_char(tx_char),
        .i_rx_char(tx_char), .i_rx_par(rx_par), .i_rx_pin(rx_pin),
        .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_dcd_n(dcd_n), .i_ri_n(ri_n),
        .o_tx(tx), .o_rx_serial(rx_ser), .o_rts_n(rts_n), .o_dtr_n(dtr_n),
        .o_user_output_a_n(ua_n), .o_user_output_b_n(ub_n), .o_irq(irq),
        .o_fmt(fmt), .o_tx_par(tx_par), .o_rx_par_err(par_err),
        .o_divisor(divisor), .o_efr(efr), .o_auto_flow_en(afe),
        .o_fifo_en(fifo_en), .o_rx_fifo_clr(), .o_tx_fifo_clr()
    );

    ucc_modem_model modem (
        .i_core_clk(clk), .i_line_tx(tx), .o_line_rx(rx_pin),
        .o_cts_n(cts_n), .o_dsr_n(dsr_n), .o_dcd_n(dcd_n), .o_ri_n(ri_n)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        num_checks++;
        if (exp !== got) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one idle edge between requests keeps each strobe a single pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic interrupt_identification(input logic [7:0] exp);
        rd(`UCC_OFF_ISR, v);
        chk("isr", exp, v);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic pulse_events();
        @(posedge clk);
        line_ev <= 1'b1;
        tmo     <= 1'b1;
        @(posedge clk);
        line_ev <= 1'b0;
        tmo     <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #200000;
        err_count++;
        wrap_up();
    end

    initial begin
        err_count  = 0;
        num_checks = 0;
        rst_n   = 1'b0;
        bus     = '0;
        line_ev = 1'b0;
        tmo     = 1'b0;
        fill    = 5'h00;
        thr     = 1'b0;
        tx_char = 8'h01;
        rx_par  = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        interrupt_identification(8'h01);
        chk("tx idle", 1, tx);
        chk("rts dtr", 2'h3, {rts_n, dtr_n});
        // word length and stop length for every encoding
        for (int i = 0; i < 4; i++) begin
            wr(`UCC_OFF_LCR, 8'h04 | 8'(i));
            settle();
            chk("wlen", 16'(i), 16'(fmt.wlen));
            chk("stop", (i == 0) ? 3 : 4, 16'(fmt.stop_halves));
        end
        wr(`UCC_OFF_LCR, 8'h03);
        settle();
        chk("stop one", 2, 16'(fmt.stop_halves));
        chk("par off", 0, {par_err, fmt.par_en});
        // odd, even, forced one, forced zero on one set bit
        for (int i = 0; i < 4; i++) begin
            wr(`UCC_OFF_LCR, 8'h0B | 8'(i << 4));
            settle();
            v = (i == 1 || i == 2) ? 8'h01 : 8'h00;
            chk("fmt par", 16'(i), {fmt.par_stick, fmt.par_even});
            chk("tx par", 16'(v), 16'(tx_par));
            chk("rx par err", 16'(v), 16'(par_err));
        end
        rd(`UCC_OFF_LCR, v);
        chk("line rd", 8'h3B, v);
        wr(`UCC_OFF_LCR, 8'h43);
        settle();
        chk("break", 0, tx);
        wr(`UCC_OFF_LCR, 8'h83);
        wr(`UCC_OFF_DLL, 8'h34);
        wr(`UCC_OFF_IER, 8'h12);
        wr(`UCC_OFF_ISR, 8'h5A);
        settle();
        chk("divisor", 16'h1234, divisor);
        chk("efr", 8'h5A, efr);
        wr(`UCC_OFF_LCR, 8'h03);
        settle();
        chk("break off", 1, tx);
        rd(`UCC_OFF_DLL, v);
        chk("dll hidden", 8'h00, v);
        rd(8'h1C, v);
        chk("unmapped", 8'h00, v);
        wr(`UCC_OFF_MCR, 8'hEB);
        settle();
        rd(`UCC_OFF_MCR, v);
        chk("mcr rd", 8'h2B, v);
        chk("afe", 1, afe);
        chk("outs", 4'h2, {rts_n, dtr_n, ua_n, ub_n});
        wr(`UCC_OFF_MCR, 8'h04);
        settle();
        chk("user a", 4'hD, {rts_n, dtr_n, ua_n, ub_n});
        // every source at once, then drained one read at a time
        wr(`UCC_OFF_MCR, 8'h00);
        wr(`UCC_OFF_IER, 8'h0F);
        fork
            pulse_events();
            modem.assert_cts();
        join
        fill <= 5'h01;
        thr  <= 1'b1;
        settle();
        chk("irq", 1, irq);
        interrupt_identification(8'h06);
        chk("irq held", 1, irq);
        interrupt_identification(8'h04);
        interrupt_identification(8'h0C);
        // data is a level: it is shown again once the time-out is read
        interrupt_identification(8'h04);
        @(posedge clk) fill <= 5'h00;
        settle();
        interrupt_identification(8'h02);
        interrupt_identification(8'h00);
        interrupt_identification(8'h01);
        chk("irq low", 0, irq);
        // modem sources come from the control bits while looped
        wr(`UCC_OFF_IER, 8'h08);
        wr(`UCC_OFF_MCR, 8'h1F);
        settle();
        chk("loop pins", 5'h1F, {tx, rts_n, dtr_n, ua_n, ub_n});
        interrupt_identification(8'h00);
        rd(`UCC_OFF_MSR, v);
        chk("loop status", 4'hF, 16'(v[7:4]));
        wr(`UCC_OFF_LCR, 8'h43);
        settle();
        chk("loop brk", 2'h2, {tx, rx_ser});
        wr(`UCC_OFF_MCR, 8'h00);
        settle();
        // masked sources never reach the identification register
        wr(`UCC_OFF_IER, 8'h00);
        interrupt_identification(8'h01);
        pulse_events();
        settle();
        interrupt_identification(8'h01);
        chk("irq masked", 0, irq);
        // fifo mode, trigger level fourteen
        wr(`UCC_OFF_ISR, 8'hC1);
        wr(`UCC_OFF_IER, 8'h01);
        fill <= 5'h0D;
        settle();
        chk("fifo en", 1, fifo_en);
        // the time-out flagged while masked shows once enabled
        interrupt_identification(8'hCC);
        interrupt_identification(8'hC1);
        @(posedge clk) fill <= 5'h0E;
        settle();
        interrupt_identification(8'hC4);
        // reset in mid-run returns the block to its idle state
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        interrupt_identification(8'h01);
        chk("divisor rst", 16'h0000, divisor);
        wrap_up();
    end
endmodule // testbench
